/* logic/crf_byte_buf.sv */
// Two-entry byte buffer between the sequence builder and the shifter
`timescale 1ns/1ps
module crf_byte_buf (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic flush_in,
   // Fill side
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [crf_pkg::BYTE_W-1:0] wr_data_in,
   // Drain side
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [crf_pkg::BYTE_W-1:0] rd_data_out
);
   logic [crf_pkg::BYTE_W-1:0] mem_r [crf_pkg::BUF_DEPTH];
   logic [crf_pkg::BYTE_W-1:0] mem_nxt [crf_pkg::BUF_DEPTH];
   logic [crf_pkg::BUF_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [crf_pkg::BUF_PTR_W:0] cnt_r, cnt_nxt;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   // Honest full and empty flags
   assign wr_ready_out = (cnt_r != 2'(crf_pkg::BUF_DEPTH)) && !flush_in;
   assign rd_valid_out = (cnt_r != 2'h0);
   assign rd_data_out = mem_r[rp_r];
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in && !flush_in;

   // Next pointers, count and storage
   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (flush_in) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (push) begin
            mem_nxt[wp_r] = wr_data_in;
            wp_nxt = wp_r + 1'b1;
         end
         if (pop) begin
            rp_nxt = rp_r + 1'b1;
         end
         cnt_nxt = cnt_r + 2'(push) - 2'(pop);
      end
   end

   // Register stage
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < crf_pkg::BUF_DEPTH; i++) begin
            mem_r[i] <= crf_pkg::PAD_BYTE;
         end
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // crf_byte_buf

/* logic/crf_framer.sv */
// Conversion readback framer: builds and shifts the readback byte sequence
//
// Function
// - Primary sequence is 4, 5 or 6 bytes
// - Order: status, four word bytes, checksum
// - Auxiliary: three word bytes, then zero pad
// - Without status, conversion word starts sequence
// - Status byte enabled by config 02h bit 2
// - Bit 7: auxiliary data new since read
// - Bit 6: primary data new since read
// - Bit 5: clock source, 1 is external
// - Bit 4: low reference alarm
// - Bits 3/2: amplifier low/high output alarms
// - Bit 1: amplifier differential range alarm
// - Bit 0: mirrors device reset flag
// - Auxiliary new flag valid only on commands
// - Alarm bits valid only in primary readbacks
// - Two's-complement word shifted MSB first
// - Zero input gives all-zero code
// - Continued clocking repeats sequence from start
`timescale 1ns/1ps
module crf_framer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Serial link; sclk_in and cs_n_in asynchronous to clk_in, outputs registered on clk_in
   input wire logic sclk_in,
   input wire logic cs_n_in,
   output logic dout_out,
   output logic dout_oe_n_out,
   // Read requests from the command decoder
   input wire logic read_primary_command_in,
   input wire logic read_auxiliary_command_in,
   input wire logic direct_read_in,
   // Conversion results
   input wire logic [31:0] primary_converter_in,
   input wire logic primary_valid_in,
   input wire logic [23:0] auxiliary_converter_in,
   input wire logic auxiliary_valid_in,
   // Configuration
   input wire logic [7:0] iface_cfg_in,
   input wire logic checksum_en_in,
   input wire logic [7:0] checksum_in,
   // Status sources
   input wire logic clock_source_flag_in,
   input wire logic low_reference_alarm_in,
   input wire logic amp_low_output_alarm_in,
   input wire logic amp_high_output_alarm_in,
   input wire logic amp_differential_range_alarm_in,
   input wire logic reset_flag_in,
   // Observation
   output logic busy_out,
   output logic [7:0] readback_status_flags_out
);
   ////////////////////////////////////////////////////////////////////////
   // Link synchronisers and edge detection
   logic sclk_s1_r, sclk_s2_r, sclk_s3_r, csn_s1_r, csn_s2_r;
   logic sclk_rise;

   // Two flops per pin, third flop only for the edge detector
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_s3_r <= 1'b0;
         csn_s1_r <= 1'b1;
         csn_s2_r <= 1'b1;
      end else begin
         sclk_s1_r <= sclk_in;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
         csn_s1_r <= cs_n_in;
         csn_s2_r <= csn_s1_r;
      end
   end
   assign sclk_rise = sclk_s2_r && !sclk_s3_r;

   ////////////////////////////////////////////////////////////////////////
   // New-data flags
   logic prim_new_r, prim_new_nxt, aux_new_r, aux_new_nxt;
   logic start_prim, start_aux, start;

   assign start_prim = read_primary_command_in || direct_read_in;
   assign start_aux = read_auxiliary_command_in && !start_prim;
   assign start = start_prim || start_aux;

   // A fresh result wins over the clear by a read in the same cycle
   always_comb begin
      prim_new_nxt = prim_new_r;
      aux_new_nxt = aux_new_r;
      if (start_prim) begin
         prim_new_nxt = 1'b0;
      end
      if (primary_valid_in) begin
         prim_new_nxt = 1'b1;
      end
      if (start_aux) begin
         aux_new_nxt = 1'b0;
      end
      if (auxiliary_valid_in) begin
         aux_new_nxt = 1'b1;
      end
   end

   // New-data flag registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prim_new_r <= 1'b0;
         aux_new_r <= 1'b0;
      end else begin
         prim_new_r <= prim_new_nxt;
         aux_new_r <= aux_new_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Snapshot of the readback at request time
   crf_pkg::crf_state_t state_r, state_nxt;
   logic [7:0] stat_r, stat_nxt;
   logic [31:0] word_r, word_nxt;
   logic aux_sel_r, aux_sel_nxt, st_en_r, st_en_nxt, ck_en_r, ck_en_nxt;
   logic [2:0] idx_r, idx_nxt, last_r, last_nxt, k;
   logic [7:0] byte_sel;
   logic buf_ready, buf_valid, buf_pop, flush;
   logic [7:0] buf_data;

   assign flush = start || csn_s2_r;

   // Status byte, word and layout captured on a read request
   always_comb begin
      stat_nxt = stat_r;
      word_nxt = word_r;
      aux_sel_nxt = aux_sel_r;
      st_en_nxt = st_en_r;
      ck_en_nxt = ck_en_r;
      last_nxt = last_r;
      if (start) begin
         stat_nxt = crf_pkg::STATUS_RST;
         stat_nxt[crf_pkg::ST_AUX_NEW] = aux_new_r && !direct_read_in;
         stat_nxt[crf_pkg::ST_PRIM_NEW] = prim_new_r;
         stat_nxt[crf_pkg::ST_CLK_SRC] = clock_source_flag_in;
         stat_nxt[crf_pkg::ST_RESET] = reset_flag_in;
         if (start_prim) begin
            stat_nxt[crf_pkg::ST_REF_LOW] = low_reference_alarm_in;
            stat_nxt[crf_pkg::ST_AMP_LOW] = amp_low_output_alarm_in;
            stat_nxt[crf_pkg::ST_AMP_HIGH] = amp_high_output_alarm_in;
            stat_nxt[crf_pkg::ST_AMP_DIFF] = amp_differential_range_alarm_in;
            word_nxt = primary_converter_in;
         end else begin
            word_nxt = {auxiliary_converter_in, crf_pkg::PAD_BYTE};
         end
         aux_sel_nxt = start_aux;
         st_en_nxt = iface_cfg_in[crf_pkg::STATUS_EN_BIT];
         ck_en_nxt = checksum_en_in;
         last_nxt = crf_pkg::DATA_BYTES - 3'h1 + 3'(iface_cfg_in[crf_pkg::STATUS_EN_BIT])
            + 3'(checksum_en_in);
      end
   end

   // Snapshot registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stat_r <= crf_pkg::STATUS_RST;
         word_r <= crf_pkg::WORD_RST;
         aux_sel_r <= 1'b0;
         st_en_r <= 1'b0;
         ck_en_r <= 1'b0;
         last_r <= crf_pkg::DATA_BYTES - 3'h1;
      end else begin
         stat_r <= stat_nxt;
         word_r <= word_nxt;
         aux_sel_r <= aux_sel_nxt;
         st_en_r <= st_en_nxt;
         ck_en_r <= ck_en_nxt;
         last_r <= last_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence builder feeding the buffer
   assign k = idx_r - 3'(st_en_r);

   // Byte for the current position; status drops out and the rest shift left
   always_comb begin
      if (st_en_r && (idx_r == crf_pkg::IDX_RST)) begin
         byte_sel = stat_r;
      end else if (k < crf_pkg::DATA_BYTES) begin
         byte_sel = word_r[8'(31) - 8'(k) * 8'h8 -: 8];
      end else begin
         byte_sel = checksum_in;
      end
   end

   // Position advances on each accepted byte and wraps after the last
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      if (start) begin
         state_nxt = crf_pkg::CRF_RUN;
         idx_nxt = crf_pkg::IDX_RST;
      end else if (csn_s2_r) begin
         state_nxt = crf_pkg::CRF_IDLE;
         idx_nxt = crf_pkg::IDX_RST;
      end else if ((state_r == crf_pkg::CRF_RUN) && buf_ready) begin
         idx_nxt = (idx_r == last_r) ? crf_pkg::IDX_RST : idx_r + 3'h1;
      end
   end

   // Builder registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= crf_pkg::CRF_IDLE;
         idx_r <= crf_pkg::IDX_RST;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
      end
   end

   // Buffer absorbs the gap between builder and link
   crf_byte_buf u_buf (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .flush_in(flush),
      .wr_valid_in(state_r == crf_pkg::CRF_RUN),
      .wr_ready_out(buf_ready),
      .wr_data_in(byte_sel),
      .rd_valid_out(buf_valid),
      .rd_ready_in(buf_pop),
      .rd_data_out(buf_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output shifter, one bit per link clock rising edge
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic dout_r, dout_nxt, oe_n_r, oe_n_nxt;

   assign buf_pop = sclk_rise && (bit_r == crf_pkg::IDX_RST) && (state_r == crf_pkg::CRF_RUN);

   // Loads a byte every eighth edge and sends its MSB first
   always_comb begin
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      dout_nxt = dout_r;
      oe_n_nxt = csn_s2_r;
      if (flush) begin
         bit_nxt = crf_pkg::IDX_RST;
         dout_nxt = 1'b0;
      end else if (sclk_rise && (state_r == crf_pkg::CRF_RUN)) begin
         if (bit_r == crf_pkg::IDX_RST) begin
            dout_nxt = buf_valid ? buf_data[7] : 1'b0;
            sh_nxt = buf_valid ? {buf_data[6:0], 1'b0} : crf_pkg::PAD_BYTE;
            bit_nxt = crf_pkg::BIT_LAST;
         end else begin
            dout_nxt = sh_r[7];
            sh_nxt = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r - 3'h1;
         end
      end
   end

   // Shifter registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sh_r <= crf_pkg::PAD_BYTE;
         bit_r <= crf_pkg::IDX_RST;
         dout_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   assign dout_out = dout_r;
   assign dout_oe_n_out = oe_n_r;
   assign busy_out = (state_r == crf_pkg::CRF_RUN);
   assign readback_status_flags_out = stat_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   logic push_now;
   assign push_now = (state_r == crf_pkg::CRF_RUN) && buf_ready && !flush;

   sequence s_prim_req;
      start_prim && !csn_s2_r;
   endsequence
   sequence s_aux_req;
      start_aux && !csn_s2_r;
   endsequence

   a_seq_wrap: assert property (push_now && idx_r == last_r |=> idx_r == 3'h0)
      else $error("sequence did not wrap to first byte");
   a_seq_len: assert property (s_prim_req |=> last_r == 3'h3 + 3'(st_en_r) + 3'(ck_en_r))
      else $error("sequence length wrong");
   a_status_first: assert property (push_now && st_en_r && idx_r == 3'h0 |-> byte_sel == stat_r)
      else $error("status byte not first");
   a_word_first: assert property (push_now && !st_en_r && idx_r == 3'h0 |-> byte_sel == word_r[31:24])
      else $error("word MSB byte not first without status");
   a_aux_pad: assert property (push_now && aux_sel_r && k == 3'h3 |-> byte_sel == 8'h00)
      else $error("auxiliary pad byte not zero");
   a_no_checksum: assert property (push_now && !ck_en_r && k == 3'h3 |=> idx_r == 3'h0)
      else $error("trailing byte without checksum");
   a_prim_new_set: assert property (primary_valid_in |=> prim_new_r)
      else $error("primary new flag not set");
   a_prim_new_clr: assert property (s_prim_req ##0 !primary_valid_in |=> !prim_new_r)
      else $error("primary new flag not cleared by read");
   a_aux_direct: assert property (direct_read_in |=> !stat_r[crf_pkg::ST_AUX_NEW])
      else $error("auxiliary flag shown on direct read");
   a_aux_alarms: assert property (s_aux_req |=> stat_r[4:1] == 4'h0)
      else $error("alarm bits in auxiliary readback");
   a_stat_src: assert property (start |=> stat_r[crf_pkg::ST_CLK_SRC] == $past(clock_source_flag_in)
      && stat_r[crf_pkg::ST_RESET] == $past(reset_flag_in))
      else $error("clock source or reset bit wrong");
   a_cfg_bit: assert property (start |=> st_en_r == $past(iface_cfg_in[2]))
      else $error("status enable not from bit 2");
endmodule // crf_framer

/* logic/crf_pkg.sv */
// Constants and types shared by the conversion readback framer
package crf_pkg;
   // Byte buffer shape
   localparam int BYTE_W = 8;
   localparam int BUF_DEPTH = 2;
   localparam int BUF_PTR_W = 1;
   // Interface configuration register and its status enable field
   localparam logic [7:0] IFACE_CFG_ADDR = 8'h02;
   localparam int STATUS_EN_BIT = 2;
   // Status byte field positions
   localparam int ST_AUX_NEW = 7;
   localparam int ST_PRIM_NEW = 6;
   localparam int ST_CLK_SRC = 5;
   localparam int ST_REF_LOW = 4;
   localparam int ST_AMP_LOW = 3;
   localparam int ST_AMP_HIGH = 2;
   localparam int ST_AMP_DIFF = 1;
   localparam int ST_RESET = 0;
   // Sequence layout
   localparam logic [2:0] DATA_BYTES = 3'h4;
   localparam logic [2:0] AUX_PAD_POS = 3'h3;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Values after reset
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [2:0] IDX_RST = 3'h0;
   // Sequencer states
   typedef enum logic [0:0] {
      CRF_IDLE = 1'b0,
      CRF_RUN = 1'b1
   } crf_state_t;
endpackage

/* tb/crf_framer_tb_top.sv */
// Self-checking bench for the conversion readback framer
`timescale 1ns/1ps
module crf_framer_tb_top;
   logic clk_in, nrst_in, sclk, cs_n, dout, oe_n, busy, rx_stb;
   logic rd_p, rd_a, rd_d, pv, av, ck_en, csrc, rlow, alo, ahi, adif, rflag;
   logic [31:0] pw, host_w;
   logic [23:0] aw;
   logic [7:0] cfg, ck, st_out, rx_byte;
   logic [7:0] exp_q[$];
   logic prim_new, aux_new;
   int seed, miscompares, tests_run, cyc, tnum;
   crf_framer u_crf_framer (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .dout_out(dout), .dout_oe_n_out(oe_n), .read_primary_command_in(rd_p),
      .read_auxiliary_command_in(rd_a), .direct_read_in(rd_d), .primary_converter_in(pw),
      .primary_valid_in(pv), .auxiliary_converter_in(aw), .auxiliary_valid_in(av),
      .iface_cfg_in(cfg), .checksum_en_in(ck_en), .checksum_in(ck), .clock_source_flag_in(csrc),
      .low_reference_alarm_in(rlow), .amp_low_output_alarm_in(alo), .amp_high_output_alarm_in(ahi),
      .amp_differential_range_alarm_in(adif), .reset_flag_in(rflag), .busy_out(busy),
      .readback_status_flags_out(st_out));
   crf_host_model u_crf_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .dout_in(dout),
      .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));
   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Scoreboard: oldest note against each captured byte
   always @(posedge rx_stb) begin
      host_w = {host_w[23:0], rx_byte};
      if (exp_q.size() == 0) begin
         miscompares++;
         $display("[FAIL] %0t byte without note", $time);
      end else
         check(rx_byte, exp_q.pop_front());
   end
   // Hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // New data pulses
   task automatic new_data(input logic p, input logic a);
      @(posedge clk_in);
      pv <= p;
      av <= a;
      @(posedge clk_in);
      pv <= 1'b0;
      av <= 1'b0;
      prim_new = prim_new | p;
      aux_new = aux_new | a;
   endtask
   // One readback: kind 0 primary command, 1 auxiliary command, 2 direct
   task automatic rd(input int kind, input logic se, input logic ce, input logic zw, input int nb);
      logic [7:0] seq[$];
      logic [7:0] st;
      logic [31:0] w;
      logic [31:0] r;
      w = zw ? 32'h0000_0000 : $random(seed);
      r = $random(seed);
      @(posedge clk_in);
      pw <= w;
      aw <= w[23:0];
      cfg <= {r[7:3], se, r[1:0]};
      ck_en <= ce;
      ck <= r[23:16];
      {csrc, rlow, alo, ahi, adif, rflag} <= r[14:9];
      st = 8'h00;
      st[7] = (kind == 1 || kind == 0) & aux_new;
      st[6] = prim_new;
      st[5] = r[14];
      st[0] = r[9];
      if (kind != 1)
         st[4:1] = r[13:10];
      if (se)
         seq.push_back(st);
      if (kind == 1)
         seq = {seq, w[23:16], w[15:8], w[7:0], 8'h00};
      else
         seq = {seq, w[31:24], w[23:16], w[15:8], w[7:0]};
      if (ce)
         seq.push_back(r[23:16]);
      for (int i = 0; i < nb; i++)
         exp_q.push_back(seq[i % seq.size()]);
      u_crf_host_model.select();
      @(posedge clk_in);
      #1 check({7'h00, oe_n}, 8'h00);
      // Request pulse is launched on a rising edge
      @(posedge clk_in);
      rd_p <= (kind == 0);
      rd_a <= (kind == 1);
      rd_d <= (kind == 2);
      @(posedge clk_in);
      rd_p <= 1'b0;
      rd_a <= 1'b0;
      rd_d <= 1'b0;
      #1 check(st_out, st);
      check({7'h00, busy}, 8'h01);
      if (kind == 1)
         aux_new = 1'b0;
      else
         prim_new = 1'b0;
      u_crf_host_model.shift(nb, $unsigned($random(seed)) % 200);
      check(8'(exp_q.size()), 8'h00);
      // Host side reduction of a clean primary word to its upper 24 bits
      if (kind == 0 && !se && !ce && nb % 4 == 0)
         check(8'(host_w[31:8] != w[31:8]), 8'h00);
      u_crf_host_model.deselect();
      repeat (4) @(posedge clk_in);
      #1 check({6'h00, busy, oe_n}, 8'h01);
      tnum++;
      $display("test %0d done", tnum);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 84;
      {rd_p, rd_a, rd_d, pv, av, ck_en, csrc, rlow, alo, ahi, adif, rflag} = 12'h000;
      pw = 32'h0000_0000;
      aw = 24'h00_0000;
      cfg = 8'h00;
      ck = 8'h00;
      prim_new = 1'b0;
      aux_new = 1'b0;
      miscompares = 0;
      tests_run = 0;
      cyc = 0;
      tnum = 0;
      nrst_in = 1'b0;
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      new_data(1'b1, 1'b1);
      rd(0, 1'b1, 1'b1, 1'b0, 8);
      rd(0, 1'b1, 1'b0, 1'b0, 7);
      rd(1, 1'b1, 1'b1, 1'b0, 6);
      rd(1, 1'b0, 1'b0, 1'b0, 5);
      new_data(1'b1, 1'b1);
      rd(2, 1'b1, 1'b0, 1'b0, 5);
      rd(0, 1'b0, 1'b0, 1'b1, 8);
      rd(1, 1'b1, 1'b0, 1'b0, 3);
      for (int i = 0; i < 4; i++) begin
         new_data(1'($random(seed)), 1'($random(seed)));
         rd($unsigned($random(seed)) % 3, 1'($random(seed)), 1'($random(seed)), 1'b0, 7);
      end
      results();
   end
endmodule // crf_framer_tb_top

/* tb/crf_host_model.sv */
// Host serial master model: select, link clock and byte capture
`timescale 1ns/1ps
module crf_host_model (
   // Link
   output logic sclk_out,
   output logic cs_n_out,
   input wire logic dout_in,
   // Captured bytes
   output logic [7:0] rx_byte_out,
   output logic rx_stb_out
);
   // Link clock rests low outside frames
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      rx_byte_out = 8'h00;
      rx_stb_out = 1'b0;
   end
   // Select, then leave time for the sync flops
   task automatic select();
      cs_n_out = 1'b0;
      #40;
   endtask
   task automatic deselect();
      #10;
      cs_n_out = 1'b1;
      #40;
   endtask
   // Eight rises a byte, sampled before each fall; gap stalls after every second byte
   task automatic shift(input int n, input int gap);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin
            sclk_out = 1'b1;
            #24;
            b[k] = dout_in;
            sclk_out = 1'b0;
            #24;
         end
         rx_byte_out = b;
         rx_stb_out = 1'b1;
         #1;
         rx_stb_out = 1'b0;
         #(gap * (i % 2));
      end
   endtask
endmodule // crf_host_model
